// ### hw/sfes_pkg.sv
// Shared constants for the serial flash erase and suspend sequencer.
// Assumes a 20 MHz core clock and a 32 MB die addressed in 64 KB blocks.
package sfes_pkg;
   localparam int CLK_MHZ = 20;

   // Command opcodes
   localparam logic [7:0] OP_WREN = 8'h06;
   localparam logic [7:0] OP_RDSR1 = 8'h05;
   localparam logic [7:0] OP_RDSR2 = 8'h35;
   localparam logic [7:0] OP_SECT = 8'h20;
   localparam logic [7:0] OP_SECT4 = 8'h21;
   localparam logic [7:0] OP_HALF = 8'h52;
   localparam logic [7:0] OP_BLK = 8'hd8;
   localparam logic [7:0] OP_BLK4 = 8'hdc;
   localparam logic [7:0] OP_DIE_A = 8'hc7;
   localparam logic [7:0] OP_DIE_B = 8'h60;
   localparam logic [7:0] OP_SUSP = 8'h75;
   localparam logic [7:0] OP_RESUME = 8'h7a;

   // Widths
   localparam int ADDR_W = 25;
   localparam int WORD_W = 40;
   localparam int TMR_W = 24;
   localparam int LAT_W = 12;
   localparam int BLK_W = 9;
   localparam int BLK_LSB = 16;

   // Frame lengths in bits and the bit counter ceiling
   localparam logic [5:0] LEN_OP = 6'h08;
   localparam logic [5:0] LEN_A3 = 6'h20;
   localparam logic [5:0] LEN_A4 = 6'h28;
   localparam logic [5:0] CNT_MAX = 6'h3f;

   // Region alignment masks
   localparam logic [ADDR_W-1:0] SECT_MASK = 25'h1fff000;
   localparam logic [ADDR_W-1:0] HALF_MASK = 25'h1ff8000;
   localparam logic [ADDR_W-1:0] BLK_MASK = 25'h1ff0000;

   // Block protect field
   localparam logic [9:0] DIE_BLOCKS = 10'h200;
   localparam logic [3:0] BP_NONE = 4'h0;
   localparam logic [3:0] BP_ALL = 4'ha;

   // Status bit positions
   localparam int SR1_BUSY = 0;
   localparam int SR1_WEL = 1;
   localparam int SR2_SUS = 7;

   // Times and derived cycle counts
   localparam int SECT_ERASE_US = 100;
   localparam int HALF_BLOCK_ERASE_US = 200;
   localparam int BLOCK_ERASE_US = 400;
   localparam int DIE_ERASE_US = 2000;
   localparam int SUS_LAT_US = 20;
   localparam int RESUME_BUSY_NS = 200;
   localparam int SECT_ERASE_CYC = SECT_ERASE_US * CLK_MHZ;
   localparam int HALF_BLOCK_ERASE_CYC = HALF_BLOCK_ERASE_US * CLK_MHZ;
   localparam int BLOCK_ERASE_CYC = BLOCK_ERASE_US * CLK_MHZ;
   localparam int DIE_ERASE_CYC = DIE_ERASE_US * CLK_MHZ;
   localparam int SUS_LAT_CYC = SUS_LAT_US * CLK_MHZ;
   localparam int RESUME_BUSY_CYC = (RESUME_BUSY_NS * CLK_MHZ) / 1000;

   typedef enum logic [1:0] {
      ST_IDLE = 2'h0,
      ST_ERASE = 2'h1,
      ST_SUSP_WAIT = 2'h3,
      ST_SUSPENDED = 2'h2
   } sfes_state_t;

   typedef enum logic [1:0] {
      KIND_SECT = 2'h0,
      KIND_HALF = 2'h1,
      KIND_BLK = 2'h2,
      KIND_DIE = 2'h3
   } sfes_kind_t;
endpackage

// ### hw/sfes_eraser.sv
// Erase and suspend sequencer of one flash die, behind its serial pins.
// Assumes the protect inputs and address mode come from core-clock logic,
// and that the host keeps the serial clock idle while select is high.
//
// Contract
// - Sector erase clears addressed 4 KB to ones
// - Erase rejected unless write enable latch set
// - Select must rise on byte boundary, else discard
// - Select rise starts erase; busy held throughout
// - Status read answered while erase runs
// - Completion clears write enable latch
// - Protected or locked target is not erased
// - 21h and DCh always take 32-bit address
// - 32 KB block erase like sector erase
// - 64 KB block erase like sector erase
// - Die erase: two opcodes, eight bits only
// - Die erase refused if anything protected
// - Each die runs its own die erase
// - Suspend only when idle-flagged, busy, erasing
// - Suspend ignored during die erase
// - No erase accepted while suspended
// - Suspend sets flag now, busy drops later
// - Other regions usable while suspended
// - Power loss clears suspend flag
// - Resume clears flag, busy within 200 ns
`timescale 1ns/10ps
`default_nettype none
module sfes_eraser #(
   parameter int SECT_CYC = sfes_pkg::SECT_ERASE_CYC,
   parameter int HALF_CYC = sfes_pkg::HALF_BLOCK_ERASE_CYC,
   parameter int BLK_CYC = sfes_pkg::BLOCK_ERASE_CYC,
   parameter int DIE_CYC = sfes_pkg::DIE_ERASE_CYC
) (
   // Core clock and reset
   input wire logic core_clk_i,
   input wire logic rst_b_i,
   // Serial link
   input wire logic sclk_i,
   input wire logic cs_b_i,
   input wire logic mosi_i,
   output logic miso_o,
   output logic miso_oe_o,
   // Configuration
   input wire logic addr4_mode_i,
   input wire logic block_protect_bit3_i,
   input wire logic block_protect_bit2_i,
   input wire logic block_protect_bit1_i,
   input wire logic block_protect_bit0_i,
   input wire logic top_bottom_select_i,
   input wire logic protect_complement_i,
   input wire logic [511:0] block_lock_i,
   // Status
   output logic busy_o,
   output logic write_enable_latch_o,
   output logic suspend_flag_o,
   // Erase engine
   output logic erase_start_o,
   output logic [1:0] erase_kind_o,
   output logic [sfes_pkg::ADDR_W-1:0] erase_base_o,
   output logic erase_done_o
);
   typedef struct packed {
      sfes_pkg::sfes_state_t st;
      logic busy, write_enable_latch, suspend_flag;
      logic cs_s1, cs_s2, cs_s3;
      logic tg_s1, tg_s2, tg_seen;
      sfes_pkg::sfes_kind_t kind;
      logic [sfes_pkg::ADDR_W-1:0] base;
      logic [sfes_pkg::TMR_W-1:0] tmr;
      logic [sfes_pkg::LAT_W-1:0] lat;
      logic go, done;
   } sfes_core_t;
   typedef struct packed {
      logic [5:0] cnt;
      logic rd1, rd2;
      logic [2:0] st_s1, st_s2;
   } sfes_link_t;
   typedef struct packed {
      logic [5:0] cnt;
      logic [sfes_pkg::WORD_W-1:0] word;
      logic tgl;
   } sfes_res_t;
   typedef struct packed {
      logic d, oe;
   } sfes_miso_t;

   sfes_core_t core, next_core;
   sfes_link_t lk, next_lk;
   sfes_res_t res, next_res;
   sfes_miso_t mo, next_mo;
   logic [3:0] bp;
   assign bp = {block_protect_bit3_i, block_protect_bit2_i,
                block_protect_bit1_i, block_protect_bit0_i};

   // Block index hit by the protect field, in 64 KB units
   function automatic logic prot_blk(input logic [sfes_pkg::BLK_W-1:0] idx,
                                     input logic [3:0] bpv,
                                     input logic tb,
                                     input logic cmp);
      logic [9:0] n;
      logic hit;
      n = 10'h000;
      hit = 1'b0;
      if (bpv >= sfes_pkg::BP_ALL) begin
         hit = 1'b1;
      end else if (bpv != sfes_pkg::BP_NONE) begin
         n = 10'h001 << (bpv - 4'h1);
         hit = tb ? ({1'b0, idx} < n)
                  : ({1'b0, idx} >= (sfes_pkg::DIE_BLOCKS - n));
      end
      return hit ^ cmp;
   endfunction

   // Link domain: bit counter and read selects live only for one frame
   always_comb begin
      next_lk = lk;
      next_lk.cnt = (lk.cnt == sfes_pkg::CNT_MAX) ? lk.cnt : lk.cnt + 6'h01;
      if (lk.cnt == 6'h07) begin
         next_lk.rd1 = ({res.word[6:0], mosi_i} == sfes_pkg::OP_RDSR1);
         next_lk.rd2 = ({res.word[6:0], mosi_i} == sfes_pkg::OP_RDSR2);
      end
      next_lk.st_s1 = {core.suspend_flag, core.write_enable_latch, core.busy};
      next_lk.st_s2 = lk.st_s1;
      next_res.cnt = next_lk.cnt;
      next_res.word = {res.word[sfes_pkg::WORD_W-2:0], mosi_i};
      // Toggle marks a new frame so a select pulse without clocks is ignored
      next_res.tgl = (lk.cnt == 6'h00) ? ~res.tgl : res.tgl;
   end

   always_ff @(posedge sclk_i or posedge cs_b_i) begin
      if (cs_b_i) begin
         lk <= '0;
      end else begin
         lk <= next_lk;
      end
   end

   // Frame result survives select rise; core samples it once sclk is idle
   always_ff @(posedge sclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         res <= '0;
      end else begin
         res <= next_res;
      end
   end

   always_comb begin
      logic [7:0] sb;
      sb = 8'h00;
      sb[sfes_pkg::SR1_BUSY] = lk.rd1 & lk.st_s2[0];
      sb[sfes_pkg::SR1_WEL] = lk.rd1 & lk.st_s2[1];
      sb[sfes_pkg::SR2_SUS] = lk.rd2 & lk.st_s2[2];
      next_mo.oe = lk.rd1 | lk.rd2;
      next_mo.d = sb[3'h7 - lk.cnt[2:0]];
   end

   always_ff @(negedge sclk_i or posedge cs_b_i) begin
      if (cs_b_i) begin
         mo <= '0;
      end else begin
         mo <= next_mo;
      end
   end

   // Core domain
   always_comb begin
      logic [7:0] op;
      logic [sfes_pkg::ADDR_W-1:0] addr, mask;
      logic [5:0] need;
      logic [sfes_pkg::BLK_W-1:0] bidx;
      logic fend, is_erase, prot;
      sfes_pkg::sfes_kind_t kind;
      int dur;
      op = 8'h00;
      addr = '0;
      mask = '0;
      need = addr4_mode_i ? sfes_pkg::LEN_A4 : sfes_pkg::LEN_A3;
      bidx = '0;
      fend = 1'b0;
      is_erase = 1'b1;
      prot = 1'b0;
      kind = sfes_pkg::KIND_SECT;
      dur = SECT_CYC;
      next_core = core;
      next_core.cs_s1 = cs_b_i;
      next_core.cs_s2 = core.cs_s1;
      next_core.cs_s3 = core.cs_s2;
      next_core.tg_s1 = res.tgl;
      next_core.tg_s2 = core.tg_s1;
      next_core.go = 1'b0;
      next_core.done = 1'b0;
      if (core.cs_s2 && !core.cs_s3) begin
         fend = (core.tg_s2 != core.tg_seen);
         next_core.tg_seen = core.tg_s2;
      end
      // Only whole-byte frames of a known length decode
      unique case (res.cnt)
         sfes_pkg::LEN_OP: op = res.word[7:0];
         sfes_pkg::LEN_A3: begin
            op = res.word[31:24];
            addr = {1'b0, res.word[23:0]};
         end
         sfes_pkg::LEN_A4: begin
            op = res.word[39:32];
            addr = res.word[sfes_pkg::ADDR_W-1:0];
         end
         default: op = 8'h00;
      endcase
      unique case (op)
         sfes_pkg::OP_SECT: ; // Defaults already describe a sector erase
         sfes_pkg::OP_SECT4: need = sfes_pkg::LEN_A4;
         sfes_pkg::OP_HALF: kind = sfes_pkg::KIND_HALF;
         sfes_pkg::OP_BLK: kind = sfes_pkg::KIND_BLK;
         sfes_pkg::OP_BLK4: begin
            kind = sfes_pkg::KIND_BLK;
            need = sfes_pkg::LEN_A4;
         end
         sfes_pkg::OP_DIE_A, sfes_pkg::OP_DIE_B: begin
            kind = sfes_pkg::KIND_DIE;
            need = sfes_pkg::LEN_OP;
         end
         default: is_erase = 1'b0;
      endcase
      unique case (kind)
         sfes_pkg::KIND_SECT: mask = sfes_pkg::SECT_MASK;
         sfes_pkg::KIND_HALF: begin
            mask = sfes_pkg::HALF_MASK;
            dur = HALF_CYC;
         end
         sfes_pkg::KIND_BLK: begin
            mask = sfes_pkg::BLK_MASK;
            dur = BLK_CYC;
         end
         sfes_pkg::KIND_DIE: dur = DIE_CYC;
      endcase
      bidx = addr[sfes_pkg::ADDR_W-1:sfes_pkg::BLK_LSB];
      if (kind == sfes_pkg::KIND_DIE) begin
         prot = (protect_complement_i ? (bp < sfes_pkg::BP_ALL)
                                      : (bp != sfes_pkg::BP_NONE))
                | (|block_lock_i);
      end else begin
         prot = prot_blk(bidx, bp, top_bottom_select_i, protect_complement_i)
                | block_lock_i[bidx];
      end
      // Self-timed progress
      unique case (core.st)
         sfes_pkg::ST_ERASE: begin
            if (core.tmr == '0) begin
               next_core.st = sfes_pkg::ST_IDLE;
               next_core.busy = 1'b0;
               next_core.write_enable_latch = 1'b0;
               next_core.done = 1'b1;
            end else begin
               next_core.tmr = core.tmr - 1'b1;
            end
         end
         sfes_pkg::ST_SUSP_WAIT: begin
            if (core.lat == '0) begin
               next_core.st = sfes_pkg::ST_SUSPENDED;
               next_core.busy = 1'b0;
            end else begin
               next_core.lat = core.lat - 1'b1;
            end
         end
         sfes_pkg::ST_IDLE, sfes_pkg::ST_SUSPENDED: ;
      endcase
      if (fend) begin
         if (op == sfes_pkg::OP_SUSP && res.cnt == sfes_pkg::LEN_OP) begin
            // Not on the completing cycle, never during die erase
            if (core.st == sfes_pkg::ST_ERASE && !core.suspend_flag && core.busy &&
                core.kind != sfes_pkg::KIND_DIE &&
                core.tmr != '0) begin
               next_core.st = sfes_pkg::ST_SUSP_WAIT;
               next_core.suspend_flag = 1'b1;
               next_core.lat = sfes_pkg::LAT_W'(sfes_pkg::SUS_LAT_CYC - 1);
            end
         end else if (op == sfes_pkg::OP_RESUME &&
                      res.cnt == sfes_pkg::LEN_OP) begin
            if (core.st == sfes_pkg::ST_SUSPENDED && core.suspend_flag &&
                !core.busy) begin
               next_core.st = sfes_pkg::ST_ERASE;
               next_core.suspend_flag = 1'b0;
               next_core.busy = 1'b1;
            end
         end else if (!core.busy) begin
            if (op == sfes_pkg::OP_WREN && res.cnt == sfes_pkg::LEN_OP) begin
               next_core.write_enable_latch = 1'b1;
            end else if (is_erase && core.write_enable_latch && !core.suspend_flag &&
                         res.cnt == need && !prot) begin
               next_core.st = sfes_pkg::ST_ERASE;
               next_core.busy = 1'b1;
               next_core.kind = kind;
               next_core.base = addr & mask;
               next_core.tmr = sfes_pkg::TMR_W'(dur - 1);
               next_core.go = 1'b1;
            end
         end
      end
   end

   // Reset doubles as power loss: suspend flag returns to zero
   always_ff @(posedge core_clk_i) begin
      if (!rst_b_i) begin
         core <= '0;
      end else begin
         core <= next_core;
      end
   end

   assign miso_o = mo.d;
   assign miso_oe_o = mo.oe;
   assign busy_o = core.busy;
   assign write_enable_latch_o = core.write_enable_latch;
   assign suspend_flag_o = core.suspend_flag;
   assign erase_start_o = core.go;
   assign erase_kind_o = core.kind;
   assign erase_base_o = core.base;
   assign erase_done_o = core.done;
   localparam int SUS_MAX = sfes_pkg::SUS_LAT_CYC;
   localparam int RES_MAX = sfes_pkg::RESUME_BUSY_CYC;
   default clocking cb @(posedge core_clk_i);
   endclocking
   default disable iff (!rst_b_i);

   chk_busy_start: assert property (
      erase_start_o |-> busy_o && !$past(busy_o))
      else $error("erase started without busy rising");
   chk_wel_done: assert property (
      erase_done_o |-> !write_enable_latch_o && !busy_o && $past(busy_o))
      else $error("erase completion left latch or busy set");
   chk_start_gate: assert property (
      erase_start_o |-> $past(write_enable_latch_o) && !$past(suspend_flag_o))
      else $error("erase started without latch or while suspended");
   chk_sus_drop: assert property (
      $rose(suspend_flag_o) |-> busy_o ##[1:SUS_MAX] !busy_o)
      else $error("busy did not drop within suspend latency");
   chk_sus_cause: assert property (
      $rose(suspend_flag_o) |->
         $past(busy_o) && $past(core.kind) != sfes_pkg::KIND_DIE)
      else $error("suspend taken while idle or during die erase");
   chk_resume_busy: assert property (
      $fell(suspend_flag_o) |-> ##[0:RES_MAX] busy_o)
      else $error("busy not raised after resume");
   chk_sect_align: assert property (
      erase_start_o && erase_kind_o == sfes_pkg::KIND_SECT |->
         erase_base_o[11:0] == 12'h000)
      else $error("sector base not aligned");
   chk_lock_block: assert property (
      erase_start_o |->
         !block_lock_i[erase_base_o[sfes_pkg::ADDR_W-1:sfes_pkg::BLK_LSB]])
      else $error("locked block erased");
   chk_frame_len: assert property (
      erase_start_o |-> (erase_kind_o == sfes_pkg::KIND_DIE) ?
         res.cnt == sfes_pkg::LEN_OP : res.cnt != sfes_pkg::LEN_OP)
      else $error("erase started from a frame of wrong length");

   cov_sect_erase: cover property (
      erase_start_o && erase_kind_o == sfes_pkg::KIND_SECT);
   cov_suspend: cover property ($rose(suspend_flag_o));
   cov_resume: cover property ($fell(suspend_flag_o));
   cov_die_done: cover property (
      erase_done_o && erase_kind_o == sfes_pkg::KIND_DIE);
endmodule
`default_nettype wire

// ### bench/sfes_host_model.sv
// Serial host that drives select, clock and data into one flash die.
// Assumes the bench calls frame() and that the die answers on miso.
`timescale 1ns/10ps
`default_nettype none
module sfes_host_model (
   // Answer from the die
   input wire logic miso_i,
   input wire logic miso_oe_i,
   // Serial pins
   output logic sclk_o,
   output logic cs_b_o,
   output logic mosi_o
);
   // A real rising select edge clears the die's link-side state before use
   initial begin
      sclk_o = 1'b0;
      cs_b_o = 1'b0;
      mosi_o = 1'b1;
      #1 cs_b_o = 1'b1;
   end

   // Sends n bits MSB first from the top of bits, then clocks in nrd bits
   task automatic frame(input logic [39:0] bits, input int n, input int nrd,
                        output logic [7:0] rd);
      rd = 8'h00;
      cs_b_o = 1'b0;
      for (int i = 0; i < n + nrd; i++) begin
         mosi_o = (i < n) ? bits[39 - i] : ~mosi_o;
         #7.5 sclk_o = 1'b1;
         if (i >= n) begin
            rd = {rd[6:0], ((miso_oe_i === 1'b1) ? miso_i : 1'bx)};
         end
         #7.5 sclk_o = 1'b0;
      end
      #7.5 cs_b_o = 1'b1;
      // Released data line must not keep its last level
      mosi_o = ~mosi_o;
      // Clock stays idle well past the minimum gap between frames
      #300;
   endtask
endmodule
`default_nettype wire

// ### bench/tb_top.sv
// Self-checking bench for the erase and suspend sequencer.
// Assumes the host model drives the link; core inputs change after edges.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
   localparam int SECT_N = 200;
   localparam int HALF_N = 300;
   localparam int BLK_N = 400;
   localparam int DIE_N = 500;
   logic core_clk = 1'b0;
   logic rst_b = 1'b1;
   logic addr4 = 1'b0;
   logic [3:0] bp = 4'h0;
   logic tb_sel = 1'b0;
   logic cmp = 1'b0;
   logic [511:0] lock = 512'h0;
   wire logic sclk, cs_b, mosi, miso, miso_oe, busy, write_enable_latch, suspend_flag;
   wire logic e_start, e_done;
   wire logic [1:0] e_kind;
   wire logic [24:0] e_base;
   int errors = 0;
   int cmp_count = 0;
   int cyc = 0, starts = 0, dones = 0, t_start = 0, t_done = 0;
   logic [1:0] kind = 2'h0;
   logic [24:0] base = 25'h0;
   logic [7:0] rd;
   string tname;

   always #25 core_clk = ~core_clk;

   sfes_eraser #(.SECT_CYC(SECT_N), .HALF_CYC(HALF_N), .BLK_CYC(BLK_N),
      .DIE_CYC(DIE_N)) dut (
      .core_clk_i(core_clk), .rst_b_i(rst_b), .sclk_i(sclk), .cs_b_i(cs_b),
      .mosi_i(mosi), .miso_o(miso), .miso_oe_o(miso_oe),
      .addr4_mode_i(addr4), .block_protect_bit3_i(bp[3]),
      .block_protect_bit2_i(bp[2]), .block_protect_bit1_i(bp[1]),
      .block_protect_bit0_i(bp[0]), .top_bottom_select_i(tb_sel),
      .protect_complement_i(cmp), .block_lock_i(lock), .busy_o(busy),
      .write_enable_latch_o(write_enable_latch), .suspend_flag_o(suspend_flag),
      .erase_start_o(e_start), .erase_kind_o(e_kind),
      .erase_base_o(e_base), .erase_done_o(e_done));

   sfes_host_model host (.miso_i(miso), .miso_oe_i(miso_oe), .sclk_o(sclk),
      .cs_b_o(cs_b), .mosi_o(mosi));

   // Start and done pulses last one cycle, so they are caught at every edge
   always @(posedge core_clk) begin
      cyc++;
      if (e_start === 1'b1) begin
         starts++;
         t_start = cyc;
         kind = e_kind;
         base = e_base;
      end
      if (e_done === 1'b1) begin
         dones++;
         t_done = cyc;
      end
   end

   task automatic chk(input logic [39:0] seen, input logic [39:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         errors++;
         $display("[FAIL] %0t %s: got %0h expected %0h", $time, tname, seen,
                  exp);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask

   task automatic send(input logic [7:0] op, input int n);
      logic [39:0] bits;
      bits = (n == 40) ? {op, 32'h001a5c3d} : {op, 24'h1a5c3d, 8'h00};
      host.frame(bits, n, 0, rd);
      tick(1);
   endtask

   task automatic wait_for(input logic on_done, input int target,
                           input int lim);
      int k;
      k = 0;
      while (((on_done ? dones : starts) < target) && k < lim) begin
         tick(1);
         k++;
      end
   endtask

   task automatic refused(input logic [7:0] op, input int n);
      int s0;
      s0 = starts;
      send(op, n);
      tick(10);
      chk(40'(starts), 40'(s0));
   endtask

   task automatic t_kinds();
      logic [7:0] ops [5];
      int lens [5];
      int durs [5];
      logic [1:0] kinds [5];
      logic [24:0] sizes [5];
      int s0, d0;
      tname = "kinds";
      ops = '{8'h20, 8'h52, 8'hd8, 8'h21, 8'hdc};
      lens = '{32, 32, 32, 40, 40};
      durs = '{SECT_N, HALF_N, BLK_N, SECT_N, BLK_N};
      kinds = '{2'h0, 2'h1, 2'h2, 2'h0, 2'h2};
      sizes = '{25'h1000, 25'h8000, 25'h10000, 25'h1000, 25'h10000};
      for (int i = 0; i < 5; i++) begin
         s0 = starts;
         d0 = dones;
         send(sfes_pkg::OP_WREN, 8);
         send(ops[i], lens[i]);
         wait_for(1'b0, s0 + 1, 10);
         chk(40'(starts), 40'(s0 + 1));
         chk(40'(kind), 40'(kinds[i]));
         chk(40'(base), 40'(25'h1a5c3d & ~(sizes[i] - 25'h1)));
         host.frame({sfes_pkg::OP_RDSR1, 32'h0}, 8, 8, rd);
         chk(40'(rd), 40'h03);
         wait_for(1'b1, d0 + 1, durs[i] + 20);
         chk(40'(t_done - t_start), 40'(durs[i]));
         chk(40'({busy, write_enable_latch}), 40'h0);
      end
      $display("%s done", tname);
   endtask

   task automatic t_refuse();
      int s0, d0;
      tname = "refuse";
      refused(8'h20, 32);
      send(sfes_pkg::OP_WREN, 8);
      refused(8'h20, 33);
      refused(8'hc7, 16);
      refused(8'h21, 32);
      addr4 = 1'b1;
      refused(8'h20, 32);
      lock[26] = 1'b1;
      refused(8'hdc, 40);
      refused(8'h60, 8);
      lock[26] = 1'b0;
      bp = 4'hf;
      refused(8'hd8, 40);
      refused(8'hc7, 8);
      bp = 4'h6;
      tb_sel = 1'b1;
      refused(8'hd8, 40);
      tb_sel = 1'b0;
      bp = 4'h0;
      s0 = starts;
      d0 = dones;
      send(8'h20, 40);
      wait_for(1'b0, s0 + 1, 10);
      chk(40'(starts), 40'(s0 + 1));
      wait_for(1'b1, d0 + 1, SECT_N + 20);
      addr4 = 1'b0;
      $display("%s done", tname);
   endtask

   task automatic t_die();
      int s0, d0;
      tname = "die";
      // Complement of a fully protected field leaves nothing protected
      bp = 4'hf;
      cmp = 1'b1;
      for (int i = 0; i < 2; i++) begin
         s0 = starts;
         d0 = dones;
         send(sfes_pkg::OP_WREN, 8);
         send(i ? sfes_pkg::OP_DIE_B : sfes_pkg::OP_DIE_A, 8);
         wait_for(1'b0, s0 + 1, 10);
         chk(40'({kind, 6'(starts - s0)}), 40'hc1);
         send(sfes_pkg::OP_SUSP, 8);
         chk(40'({suspend_flag, busy}), 40'h1);
         wait_for(1'b1, d0 + 1, DIE_N + 20);
         chk(40'(t_done - t_start), 40'(DIE_N));
      end
      bp = 4'h0;
      cmp = 1'b0;
      $display("%s done", tname);
   endtask

   task automatic t_suspend();
      int s0, d0, k;
      tname = "suspend";
      send(sfes_pkg::OP_SUSP, 8);
      chk(40'(suspend_flag), 40'h0);
      s0 = starts;
      d0 = dones;
      send(sfes_pkg::OP_WREN, 8);
      send(sfes_pkg::OP_SECT, 32);
      tick(20);
      send(sfes_pkg::OP_SUSP, 8);
      chk(40'({suspend_flag, busy}), 40'h3);
      k = 0;
      while (busy === 1'b1 && k < 450) begin
         tick(1);
         k++;
      end
      chk(40'(k <= sfes_pkg::SUS_LAT_CYC && k > 380), 40'h1);
      host.frame({sfes_pkg::OP_RDSR2, 32'h0}, 8, 8, rd);
      chk(40'(rd), 40'h80);
      host.frame({sfes_pkg::OP_RDSR1, 32'h0}, 8, 8, rd);
      chk(40'(rd), 40'h02);
      send(sfes_pkg::OP_WREN, 8);
      refused(8'h52, 32);
      send(sfes_pkg::OP_RESUME, 8);
      chk(40'({suspend_flag, busy}), 40'h1);
      wait_for(1'b1, d0 + 1, SECT_N + 20);
      chk(40'({6'(starts - s0), 6'(dones - d0), write_enable_latch}), 40'h82);
      $display("%s done", tname);
   endtask

   task automatic t_power();
      tname = "power";
      tick(sfes_pkg::SUS_LAT_CYC);
      send(sfes_pkg::OP_WREN, 8);
      send(sfes_pkg::OP_SECT, 32);
      tick(10);
      send(sfes_pkg::OP_SUSP, 8);
      chk(40'(suspend_flag), 40'h1);
      rst_b = 1'b0;
      tick(4);
      rst_b = 1'b1;
      tick(3);
      chk(40'({suspend_flag, busy, write_enable_latch}), 40'h0);
      $display("%s done", tname);
   endtask

   task automatic test_done();
      $display("comparisons %0d mismatches %0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   // Whole run is a few thousand cycles; this leaves ample margin
   initial begin
      #1000000;
      errors++;
      $display("[FAIL] %0t watchdog expired", $time);
      test_done();
   end

   initial begin
      // A real falling edge clears the die's serial-side result flops
      #1 rst_b = 1'b0;
      tick(4);
      rst_b = 1'b1;
      tick(3);
      t_kinds();
      t_refuse();
      t_die();
      t_suspend();
      t_power();
      test_done();
   end
endmodule
`default_nettype wire
